//--- hdl/upoc_defs.svh
// Register offsets, field positions, reset values and masks of the port option controller.
`ifndef UPOC_DEFS_SVH
`define UPOC_DEFS_SVH
`define UPOC_OFF_CAP        12'h000
`define UPOC_OFF_MUX        12'h004
`define UPOC_OFF_RSV0       12'h008
`define UPOC_OFF_CTL        12'h00C
`define UPOC_OFF_RSV1       12'h010
`define UPOC_OFF_RSV2       12'h014
`define UPOC_OFF_RSV3       12'h018
`define UPOC_CAP_RESET      32'h000003EA
`define UPOC_CAP_WMASK      32'h000FFFFF
`define UPOC_CTL_RESET      32'h00000200
`define UPOC_CTL_WMASK      32'h1F0F0F7C
`define UPOC_RSV0_VALUE     32'h00000800
`define UPOC_BIT_WAKE_OC    19
`define UPOC_BIT_WAKE_VB    17
`define UPOC_BIT_AUTO_PU    15
`define UPOC_BIT_OC_POL     14
`define UPOC_BIT_OCR_LO     10
`define UPOC_BIT_POL_B      9
`define UPOC_BIT_POL_A      8
`define UPOC_BIT_VBVLD      8
`define UPOC_BIT_PULLUP_ENABLE       2
`define UPOC_BIT_COMP_EN    7
`define UPOC_ROUTE_DEVICE   2'h3
`define UPOC_ROUTE_HOST     2'h2
`define UPOC_PWR_NONE       2'h0
`define UPOC_PWR_BOTH       2'h1
`define UPOC_PWR_A          2'h2
`define UPOC_PWR_B          2'h3
`endif

//--- hdl/upoc_pkg.sv
// Types shared by the port option controller.
package upoc_pkg;
  typedef struct packed {
    logic [11:0] paddr;
    logic        pwrite;
    logic [31:0] pwdata;
  } upoc_apb_req_t;
  typedef enum logic [1:0] {
    UPOC_OWN_NONE,
    UPOC_OWN_HOST,
    UPOC_OWN_DEVICE
  } upoc_owner_t;
endpackage

//--- hdl/upoc_port_option.sv
// Port option controller: APB registers, power routing, over-current and pull-up control.
//
// Design decision made here: the APB register port.
`include "upoc_defs.svh"
//
// Behaviour
// RULE1: With wake-on-over-current enabled, port 4 over-current sets the wake status.
// RULE2: With wake-on-VBUS-change enabled, any VBUS valid change sets the wake status.
// RULE3: Auto pull-up turns the pull-up on when VBUS valid is one.
// RULE4: Writing one to auto pull-up enable also sets comparator enable.
// RULE5: Over-current polarity picks the active level of the sense input.
// RULE6: Each reporting bit forwards over-current to host status for its port.
// RULE7: Polarity bit 9 sets the active level of power output B.
// RULE8: Polarity bit 8 sets the active level of power output A.
// RULE9: Two-bit routing per port: none, both, A only, B only.
// RULE10: Each power output is the OR of all ports routed to it.
// RULE11: VBUS valid flag shows comparator result, meaningful with comparator enabled.
// RULE12: In auto mode pull-up enable reads as VBUS valid and is read-only.
// RULE13: Pull-up only with comparator enabled; otherwise software bit drives it.
// RULE14: Pull-up enable is ignored unless the port is routed to device.
// RULE15: Route field: 0x none and suspended, 10 host, 11 device.
// RULE16: Comparator enable gates detection; writing zero clears auto pull-up.
// RULE17: Control route field aliases the multiplex route field.
// RULE18: Software writes reserved fields back with the values read.
// RULE19: Software keeps control bit 11 unchanged after initialisation.
// RULE20: Read-only reserved fields read as zero; the read-only RSV0 register reads 32'h00000800.
// RULE21: Polarity is applied after the OR, idle request gives inactive level.
module upoc_port_option (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [3:0]  host_port_power,
  input  wire logic        overcurrent_sense_in,
  input  wire logic        vbus_comparator_in,
  output logic             port_power_out_a,
  output logic             port_power_out_b,
  output logic      [3:0]  host_overcurrent_report,
  output logic             port4_dplus_pullup,
  output logic             vbus_comparator_enable,
  output logic             wake_event_status,
  output logic      [1:0]  port_owner,
  output logic             port_suspend
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode.
  upoc_pkg::upoc_apb_req_t req;
  logic [31:0] cap_q;
  logic [31:0] ctl_q;
  logic [1:0]  route_q;
  logic        pullup_enable_q;
  logic        vbus_q;
  logic        oc_q;
  logic        wake_q;
  logic [31:0] rsv1_q;
  logic [31:0] rsv2_q;
  logic [31:0] rsv3_q;
  logic [31:0] rdata_d;
  logic        hit;
  wire         acc        = psel && penable && !pready && clk_en;
  wire         wr         = acc && req.pwrite;
  wire         wr_cap     = wr && (req.paddr == `UPOC_OFF_CAP);
  wire         wr_mux     = wr && (req.paddr == `UPOC_OFF_MUX);
  wire         wr_ctl     = wr && (req.paddr == `UPOC_OFF_CTL);
  wire         wr_rsv1    = wr && (req.paddr == `UPOC_OFF_RSV1);
  wire         wr_rsv2    = wr && (req.paddr == `UPOC_OFF_RSV2);
  wire         wr_rsv3    = wr && (req.paddr == `UPOC_OFF_RSV3);
  wire         auto_pu    = cap_q[`UPOC_BIT_AUTO_PU];
  wire         comp_en    = ctl_q[`UPOC_BIT_COMP_EN];
  wire         vbus_valid = vbus_comparator_in && comp_en;  // [RULE11]
  wire         oc_active  = overcurrent_sense_in == cap_q[`UPOC_BIT_OC_POL];  // [RULE5]
  wire         pullup_enable_eff   = auto_pu ? vbus_valid : pullup_enable_q;  // [RULE3] [RULE12]
  wire [31:0]  mux_rd     = {23'h0, vbus_valid, 5'h0, pullup_enable_eff, route_q};  // [RULE20]
  wire [31:0]  ctl_rd     = {ctl_q[31:2], route_q};  // [RULE17]

  assign req = {paddr, pwrite, pwdata};

  always_comb begin
    hit     = 1'b1;
    rdata_d = 32'h0;
    case (req.paddr)
      `UPOC_OFF_CAP:  rdata_d = cap_q;
      `UPOC_OFF_MUX:  rdata_d = mux_rd;
      `UPOC_OFF_RSV0: rdata_d = `UPOC_RSV0_VALUE;
      `UPOC_OFF_CTL:  rdata_d = ctl_rd;
      `UPOC_OFF_RSV1: rdata_d = rsv1_q;
      `UPOC_OFF_RSV2: rdata_d = rsv2_q;
      `UPOC_OFF_RSV3: rdata_d = rsv3_q;
      default:        hit = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus answer, one wait state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else if (clk_en) begin
      pready  <= acc;
      pslverr <= acc && !hit;
      prdata  <= (acc && !req.pwrite) ? rdata_d : 32'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Capability and control registers with their cross effects.
  wire        cap_wauto = wr_cap && req.pwdata[`UPOC_BIT_AUTO_PU];
  wire        ctl_wcomp0 = wr_ctl && !req.pwdata[`UPOC_BIT_COMP_EN];
  wire [31:0] cap_w = (req.pwdata & `UPOC_CAP_WMASK);
  wire [31:0] ctl_w = (req.pwdata & `UPOC_CTL_WMASK) | {24'h0, req.pwdata[7], 7'h0};
  logic [31:0] cap_d;
  logic [31:0] ctl_d;

  always_comb begin
    cap_d = wr_cap ? cap_w : cap_q;
    ctl_d = wr_ctl ? ctl_w : ctl_q;
    if (cap_wauto) begin
      ctl_d[`UPOC_BIT_COMP_EN] = 1'b1;  // [RULE4]
    end
    if (ctl_wcomp0) begin
      cap_d[`UPOC_BIT_AUTO_PU] = 1'b0;  // [RULE16]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_q   <= `UPOC_CAP_RESET;
      ctl_q   <= `UPOC_CTL_RESET;
      route_q <= 2'h0;
      pullup_enable_q  <= 1'b0;
      rsv1_q  <= 32'h0;
      rsv2_q  <= 32'h0;
      rsv3_q  <= 32'h0;
    end else if (clk_en) begin
      cap_q <= cap_d;
      ctl_q <= ctl_d;
      if (wr_mux) begin
        route_q <= req.pwdata[1:0];  // [RULE17]
        if (!auto_pu) begin
          pullup_enable_q <= req.pwdata[`UPOC_BIT_PULLUP_ENABLE];  // [RULE12]
        end
      end else if (wr_ctl) begin
        route_q <= req.pwdata[1:0];  // [RULE17]
      end
      if (wr_rsv1) begin
        rsv1_q <= req.pwdata;
      end
      if (wr_rsv2) begin
        rsv2_q <= req.pwdata;
      end
      if (wr_rsv3) begin
        rsv3_q <= req.pwdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power routing, over-current report and ownership.
  logic [1:0] route_fld [4];
  logic       req_a;
  logic       req_b;

  always_comb begin
    req_a = 1'b0;
    req_b = 1'b0;
    for (int i = 0; i < 4; i++) begin
      route_fld[i] = cap_q[2*i +: 2];
      case (route_fld[i])  // [RULE9]
        `UPOC_PWR_BOTH: begin
          req_a = req_a | host_port_power[i];  // [RULE10]
          req_b = req_b | host_port_power[i];
        end
        `UPOC_PWR_A:    req_a = req_a | host_port_power[i];
        `UPOC_PWR_B:    req_b = req_b | host_port_power[i];
        default:        ;
      endcase
    end
  end

  wire        pwr_a_d = cap_q[`UPOC_BIT_POL_A] ? req_a : !req_a;  // [RULE8] [RULE21]
  wire        pwr_b_d = cap_q[`UPOC_BIT_POL_B] ? req_b : !req_b;  // [RULE7] [RULE21]
  wire [3:0]  ocr_d   = cap_q[`UPOC_BIT_OCR_LO +: 4] & {4{oc_active}};  // [RULE6]
  wire        dev_own = route_q == `UPOC_ROUTE_DEVICE;  // [RULE15]
  wire        pu_d    = dev_own && comp_en && pullup_enable_eff;  // [RULE13] [RULE14]
  wire        wake_oc = cap_q[`UPOC_BIT_WAKE_OC] && oc_active && !oc_q;  // [RULE1]
  wire        wake_vb = cap_q[`UPOC_BIT_WAKE_VB] && (vbus_valid != vbus_q);  // [RULE2]
  upoc_pkg::upoc_owner_t owner_d;

  assign owner_d = dev_own ? upoc_pkg::UPOC_OWN_DEVICE :
                   (route_q == `UPOC_ROUTE_HOST) ? upoc_pkg::UPOC_OWN_HOST :
                   upoc_pkg::UPOC_OWN_NONE;  // [RULE15]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_power_out_a        <= 1'b0;
      port_power_out_b        <= 1'b0;
      host_overcurrent_report <= 4'h0;
      port4_dplus_pullup      <= 1'b0;
      vbus_comparator_enable  <= 1'b0;
      port_owner              <= 2'h0;
      port_suspend            <= 1'b1;
      oc_q                    <= 1'b0;
      vbus_q                  <= 1'b0;
      wake_q                  <= 1'b0;
    end else if (clk_en) begin
      port_power_out_a        <= pwr_a_d;
      port_power_out_b        <= pwr_b_d;
      host_overcurrent_report <= ocr_d;
      port4_dplus_pullup      <= pu_d;
      vbus_comparator_enable  <= comp_en;
      port_owner              <= owner_d;
      port_suspend            <= !route_q[1];  // [RULE15]
      oc_q                    <= oc_active;
      vbus_q                  <= vbus_valid;
      wake_q                  <= wake_q | wake_oc | wake_vb;  // [RULE1] [RULE2]
    end
  end

  assign wake_event_status = wake_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  property p_wake_oc;
    @(posedge pclk) disable iff (!presetn)
      clk_en && wake_oc |=> wake_event_status;
  endproperty
  a_wake_oc: assert property (p_wake_oc) else $error("over-current wake lost"); // [RULE1]

  property p_wake_vb;
    @(posedge pclk) disable iff (!presetn)
      clk_en && cap_q[`UPOC_BIT_WAKE_VB] && $changed(vbus_valid) |=> wake_event_status;
  endproperty
  a_wake_vb: assert property (p_wake_vb) else $error("vbus wake lost"); // [RULE2]

  property p_auto_comp;
    @(posedge pclk) disable iff (!presetn)
      cap_wauto |=> ctl_q[`UPOC_BIT_COMP_EN];
  endproperty
  a_auto_comp: assert property (p_auto_comp) else $error("comparator not set"); // [RULE4]

  property p_comp_clear;
    @(posedge pclk) disable iff (!presetn)
      ctl_wcomp0 |=> !cap_q[`UPOC_BIT_AUTO_PU];
  endproperty
  a_comp_clear: assert property (p_comp_clear) else $error("auto pull-up kept"); // [RULE16]

  property p_pullup;
    @(posedge pclk) disable iff (!presetn)
      clk_en && !(dev_own && comp_en) |=> !port4_dplus_pullup;
  endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up without owner"); // [RULE14]

  property p_pwr_a;
    @(posedge pclk) disable iff (!presetn)
      clk_en && cap_q[1:0] == `UPOC_PWR_A && host_port_power[0]
        |=> port_power_out_a == $past(cap_q[`UPOC_BIT_POL_A]);
  endproperty
  a_pwr_a: assert property (p_pwr_a) else $error("power A wrong"); // [RULE8]

  property p_pwr_b_idle;
    @(posedge pclk) disable iff (!presetn)
      clk_en && !req_b |=> port_power_out_b == !$past(cap_q[`UPOC_BIT_POL_B]);
  endproperty
  a_pwr_b_idle: assert property (p_pwr_b_idle) else $error("power B idle wrong"); // [RULE21]

  property p_ocr;
    @(posedge pclk) disable iff (!presetn)
      clk_en && !cap_q[`UPOC_BIT_OCR_LO] |=> !host_overcurrent_report[0];
  endproperty
  a_ocr: assert property (p_ocr) else $error("suppressed report leaked"); // [RULE6]

  property p_alias;
    @(posedge pclk) disable iff (!presetn)
      wr_ctl |=> mux_rd[1:0] == $past(req.pwdata[1:0]);
  endproperty
  a_alias: assert property (p_alias) else $error("route alias broken"); // [RULE17]

  property p_pwr_b;
    @(posedge pclk) disable iff (!presetn)
      clk_en && cap_q[1:0] == `UPOC_PWR_B && host_port_power[0]
        |=> port_power_out_b == $past(cap_q[`UPOC_BIT_POL_B]);
  endproperty
  a_pwr_b: assert property (p_pwr_b) else $error("power B wrong"); // [RULE7]

  property p_pwr_a_idle;
    @(posedge pclk) disable iff (!presetn)
      clk_en && !req_a |=> port_power_out_a == !$past(cap_q[`UPOC_BIT_POL_A]);
  endproperty
  a_pwr_a_idle: assert property (p_pwr_a_idle) else $error("power A idle wrong"); // [RULE21]

  property p_oc_pol;
    @(posedge pclk) disable iff (!presetn)
      clk_en && cap_q[`UPOC_BIT_OCR_LO] && overcurrent_sense_in == cap_q[`UPOC_BIT_OC_POL]
        |=> host_overcurrent_report[0];
  endproperty
  a_oc_pol: assert property (p_oc_pol) else $error("over-current level missed"); // [RULE5]

  property p_ocr_port4;
    @(posedge pclk) disable iff (!presetn)
      clk_en && !cap_q[`UPOC_BIT_OCR_LO + 3] |=> !host_overcurrent_report[3];
  endproperty
  a_ocr_port4: assert property (p_ocr_port4) else $error("port 4 report leaked"); // [RULE6]

  property p_gang;
    @(posedge pclk) disable iff (!presetn)
      clk_en && cap_q[1:0] == `UPOC_PWR_BOTH && host_port_power[0]
        |=> port_power_out_a == $past(cap_q[`UPOC_BIT_POL_A]) &&
            port_power_out_b == $past(cap_q[`UPOC_BIT_POL_B]);
  endproperty
  a_gang: assert property (p_gang) else $error("ganged power wrong"); // [RULE9]

  property p_or;
    @(posedge pclk) disable iff (!presetn)
      clk_en && cap_q[5:4] == `UPOC_PWR_A && host_port_power[2]
        |=> port_power_out_a == $past(cap_q[`UPOC_BIT_POL_A]);
  endproperty
  a_or: assert property (p_or) else $error("power A request lost"); // [RULE10]

  property p_none;
    @(posedge pclk) disable iff (!presetn)
      clk_en && cap_q[7:0] == 8'h00
        |=> port_power_out_a == !$past(cap_q[`UPOC_BIT_POL_A]) &&
            port_power_out_b == !$past(cap_q[`UPOC_BIT_POL_B]);
  endproperty
  a_none: assert property (p_none) else $error("unrouted power leaked"); // [RULE9]

  property p_auto_pu;
    @(posedge pclk) disable iff (!presetn)
      clk_en && auto_pu && dev_own && comp_en && vbus_valid |=> port4_dplus_pullup;
  endproperty
  a_auto_pu: assert property (p_auto_pu) else $error("auto pull-up missing"); // [RULE3]

  property p_sw_pu;
    @(posedge pclk) disable iff (!presetn)
      clk_en && !auto_pu && dev_own && comp_en && pullup_enable_q |=> port4_dplus_pullup;
  endproperty
  a_sw_pu: assert property (p_sw_pu) else $error("software pull-up missing"); // [RULE13]

  property p_pullup_enable_ro;
    @(posedge pclk) disable iff (!presetn)
      wr_mux && auto_pu |=> $stable(pullup_enable_q);
  endproperty
  a_pullup_enable_ro: assert property (p_pullup_enable_ro) else $error("pull-up bit written in auto"); // [RULE12]

  property p_vbus_flag;
    @(posedge pclk) disable iff (!presetn)
      acc && !req.pwrite && req.paddr == `UPOC_OFF_MUX && !comp_en
        |=> !prdata[`UPOC_BIT_VBVLD];
  endproperty
  a_vbus_flag: assert property (p_vbus_flag) else $error("vbus flag without comparator"); // [RULE11]

  property p_owner_host;
    @(posedge pclk) disable iff (!presetn)
      clk_en && route_q == `UPOC_ROUTE_HOST |=> port_owner == 2'h1 && !port_suspend;
  endproperty
  a_owner_host: assert property (p_owner_host) else $error("host owner wrong"); // [RULE15]

  property p_suspend;
    @(posedge pclk) disable iff (!presetn)
      clk_en && !route_q[1] |=> port_suspend && port_owner == 2'h0;
  endproperty
  a_suspend: assert property (p_suspend) else $error("unowned port not suspended"); // [RULE15]

  property p_cap_rsvd;
    @(posedge pclk) disable iff (!presetn)
      acc && !req.pwrite && req.paddr == `UPOC_OFF_CAP
        |=> prdata[31:20] == 12'h000;
  endproperty
  a_cap_rsvd: assert property (p_cap_rsvd) else $error("capability reserved nonzero"); // [RULE20]

endmodule

//--- verif/upoc_port_model.sv
// Partner model of the over-current sensor and the VBUS comparator at the port.
module upoc_port_model (
  input  wire logic fault_cmd,
  input  wire logic sense_high,
  input  wire logic vbus_cmd,
  input  wire logic vbus_comparator_enable,
  output logic      overcurrent_sense_in,
  output logic      vbus_comparator_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // The sensor shows its active level only during a fault.
  assign overcurrent_sense_in = fault_cmd ~^ sense_high;
  // A powered-down comparator reports no VBUS.
  assign vbus_comparator_in   = vbus_cmd & vbus_comparator_enable;
endmodule

//--- verif/test_usb_port_option_control.sv
// Self-checking testbench of the port option controller.
`include "upoc_defs.svh"
module test_usb_port_option_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk       = 1'b0;
  logic        presetn    = 1'b0;
  logic        psel       = 1'b0;
  logic        penable    = 1'b0;
  logic        pwrite     = 1'b0;
  logic [11:0] paddr      = 12'h000;
  logic [31:0] pwdata     = 32'h00000000;
  logic [3:0]  host_power = 4'h0;
  logic        fault_cmd  = 1'b0;
  logic        sense_high = 1'b0;
  logic        vbus_cmd   = 1'b0;
  logic        clk_en     = 1'b1;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic [3:0]  oc_rep;
  logic [1:0]  owner;
  logic        pready, pslverr, err, oc_in, vb_in, pa, pb, pu, ce, wake, susp;
  int          failures    = 0;
  int          checks_done = 0;
  always #5 pclk = ~pclk;
  upoc_port_option dut_u (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .host_port_power(host_power),
    .overcurrent_sense_in(oc_in), .vbus_comparator_in(vb_in), .port_power_out_a(pa),
    .port_power_out_b(pb), .host_overcurrent_report(oc_rep), .port4_dplus_pullup(pu),
    .vbus_comparator_enable(ce), .wake_event_status(wake), .port_owner(owner),
    .port_suspend(susp));
  upoc_port_model model_u (.fault_cmd(fault_cmd), .sense_high(sense_high),
    .vbus_cmd(vbus_cmd), .vbus_comparator_enable(ce), .overcurrent_sense_in(oc_in),
    .vbus_comparator_in(vb_in));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      failures++;
      complete_run();
    end
  endtask
  task automatic hold;
    repeat (3) @(posedge pclk);
  endtask
  task automatic do_reset;
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_values;
    apb(1'b0, `UPOC_OFF_CAP, 32'h0);
    chk("capability", 32'h000003EA, rd);
    apb(1'b0, `UPOC_OFF_MUX, 32'h0);
    chk("multiplex", 32'h00000000, rd);
    apb(1'b0, `UPOC_OFF_CTL, 32'h0);
    chk("control", 32'h00000200, rd);
    chk("suspend", 32'h1, {31'h0, susp});
    apb(1'b0, 12'h01C, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    apb(1'b1, `UPOC_OFF_CAP, 32'hFFF00000);
    apb(1'b0, `UPOC_OFF_CAP, 32'h0);
    chk("capability reserved", 32'h0, rd);
    chk("idle power a", 32'h1, {31'h0, pa});
  endtask
  task automatic t_power;
    logic ea, eb;
    host_power <= 4'h1;
    for (int i = 0; i < 16; i++) begin
      apb(1'b1, `UPOC_OFF_CAP, {22'h0, i[3:2], 6'h0, i[1:0]});
      hold();
      ea = (i[1:0] == 2'h1) || (i[1:0] == 2'h2);
      eb = (i[1:0] == 2'h1) || (i[1:0] == 2'h3);
      chk("power a", {31'h0, ea ~^ i[2]}, {31'h0, pa});
      chk("power b", {31'h0, eb ~^ i[3]}, {31'h0, pb});
    end
    apb(1'b1, `UPOC_OFF_CAP, 32'h00000322);
    host_power <= 4'h4;
    hold();
    chk("power a or", 32'h1, {31'h0, pa});
    host_power <= 4'h0;
    hold();
    chk("power a idle", 32'h0, {31'h0, pa});
    clk_en     <= 1'b0;
    host_power <= 4'h4;
    hold();
    chk("power a frozen", 32'h0, {31'h0, pa});
    clk_en     <= 1'b1;
    hold();
    chk("power a resumed", 32'h1, {31'h0, pa});
    host_power <= 4'h0;
  endtask
  task automatic t_overcurrent;
    for (int i = 0; i < 8; i++) begin
      fault_cmd  <= i[1];
      sense_high <= i[2];
      apb(1'b1, `UPOC_OFF_CAP, {17'h0, i[0], 4'h5, 10'h0});
      hold();
      chk("report", ((i[1] ~^ i[2]) == i[0]) ? 32'h5 : 32'h0, {28'h0, oc_rep});
    end
    fault_cmd  <= 1'b0;
    sense_high <= 1'b0;
  endtask
  task automatic t_wake;
    do_reset();
    apb(1'b1, `UPOC_OFF_CTL, 32'h00000280);
    vbus_cmd <= 1'b1;
    hold();
    chk("wake off", 32'h0, {31'h0, wake});
    apb(1'b1, `UPOC_OFF_CAP, 32'h000203EA);
    vbus_cmd <= 1'b0;
    hold();
    chk("wake vbus", 32'h1, {31'h0, wake});
    do_reset();
    apb(1'b1, `UPOC_OFF_CAP, 32'h00003FEA);
    fault_cmd <= 1'b1;
    hold();
    chk("wake oc off", 32'h0, {31'h0, wake});
    fault_cmd <= 1'b0;
    apb(1'b1, `UPOC_OFF_CAP, 32'h00083FEA);
    fault_cmd <= 1'b1;
    hold();
    chk("wake oc", 32'h1, {31'h0, wake});
    fault_cmd <= 1'b0;
  endtask
  task automatic t_pullup;
    do_reset();
    apb(1'b1, `UPOC_OFF_MUX, 32'h7);
    hold();
    chk("owner device", 32'h2, {30'h0, owner});
    chk("pullup comp off", 32'h0, {31'h0, pu});
    apb(1'b1, `UPOC_OFF_CTL, 32'h00000283);
    hold();
    chk("pullup sw", 32'h1, {31'h0, pu});
    apb(1'b1, `UPOC_OFF_MUX, 32'h6);
    hold();
    chk("pullup host", 32'h0, {31'h0, pu});
    chk("owner host", 32'h1, {30'h0, owner});
    chk("suspend host", 32'h0, {31'h0, susp});
    apb(1'b1, `UPOC_OFF_CTL, 32'h00000281);
    apb(1'b0, `UPOC_OFF_MUX, 32'h0);
    chk("route alias", 32'h5, rd);
    apb(1'b1, `UPOC_OFF_CTL, 32'h00000203);
    apb(1'b1, `UPOC_OFF_CAP, 32'h000083EA);
    apb(1'b0, `UPOC_OFF_CTL, 32'h0);
    chk("auto sets comp", 32'h283, rd);
    apb(1'b1, `UPOC_OFF_MUX, 32'h3);
    hold();
    chk("pullup auto low", 32'h0, {31'h0, pu});
    vbus_cmd <= 1'b1;
    hold();
    apb(1'b0, `UPOC_OFF_MUX, 32'h0);
    chk("mux auto", 32'h107, rd);
    chk("pullup auto", 32'h1, {31'h0, pu});
    apb(1'b1, `UPOC_OFF_CTL, 32'h00000203);
    apb(1'b0, `UPOC_OFF_CAP, 32'h0);
    chk("auto cleared", 32'h3EA, rd);
    chk("comp off", 32'h0, {30'h0, ce, pu});
  endtask
  initial begin
    do_reset();
    t_reset_values();
    t_power();
    t_overcurrent();
    t_wake();
    t_pullup();
    complete_run();
  end
endmodule
